// file: pkg/cap_params_pkg.sv
package cap_params_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  STRUCT_OFFSET = 8'h04;
  localparam logic [7:0]  CAP_OFFSET    = 8'h08;
  localparam logic [7:0]  CMD_OFFSET    = 8'h0C;

  // ****************************************
  // Structural parameter fields
  // ****************************************
  localparam int          ROUTE_BIT     = 7;
  localparam int          POWER_BIT     = 4;
  localparam int          PORTS_LSB     = 0;
  localparam int          PPC_LSB       = 8;
  localparam logic [3:0]  PORT_COUNT    = 4'h4;
  localparam logic [3:0]  PER_COMPANION = 4'h2;
  localparam logic [3:0]  COMPANIONS    = 4'h2;
  localparam logic        ROUTE_RESET   = 1'b0;
  localparam logic        POWER_RESET   = 1'b1;

  // ****************************************
  // Capability parameter fields
  // ****************************************
  localparam int          WIDE_BIT      = 0;
  localparam int          PROG_BIT      = 1;
  localparam int          ISO_LSB       = 4;
  localparam logic [3:0]  ISO_RESET     = 4'h1;
  localparam logic        PROG_RESET    = 1'b1;
  localparam logic        WIDE_RESET    = 1'b0;
  localparam logic [31:0] CAP_RESET     = 32'h0000_0012;

  // ****************************************
  // Command register list size field
  // ****************************************
  localparam int          LIST_LSB      = 2;
  localparam logic [1:0]  LIST_DEFAULT  = 2'h0;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [3:0]  iso_threshold;
    logic        programmable_list_flag;
    logic        wide_pointer_flag;
  } cap_fields_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN
  } bank_state_t;

endpackage

// file: core/port_route_map.sv
`timescale 1ns/1ns
module port_route_map
  import cap_params_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        routing_rule_flag,
  input  wire logic [3:0]  ports_per_companion,
  input  wire logic [63:0] routing_array,
  input  wire logic [3:0]  port_index,
  output logic      [3:0]  companion_ff
);

  function automatic logic [3:0] group_of(input logic [3:0] idx, input logic [3:0] per);
    logic [3:0] grp;
    logic [4:0] acc;
    grp = 4'h0;
    acc = {1'b0, per};
    // Extra accumulator bit so a group edge past port 15 cannot wrap to zero
    for (int i = 0; i < 15; i++) begin
      if (per != 4'h0 && {1'b0, idx} >= acc) begin
        grp = grp + 4'h1;
        acc = acc + {1'b0, per};
      end
    end
    return grp;
  endfunction

  logic [3:0] nxt_companion;

  always_comb begin
    if (routing_rule_flag) begin
      nxt_companion = routing_array[port_index*4 +: 4];                     // [RQ1]
    end else begin
      nxt_companion = group_of(port_index, ports_per_companion);             // [RQ12]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      companion_ff <= 4'h0;
    end else begin
      companion_ff <= nxt_companion;
    end
  end

  a_route_fixed: assert property (@(posedge clock) disable iff (reset)
    routing_rule_flag |=> companion_ff == $past(routing_array[port_index*4 +: 4]))  // [RQ1]
    else $error("explicit routing mismatch");

  a_route_group: assert property (@(posedge clock) disable iff (reset)
    (!routing_rule_flag && port_index < ports_per_companion) |=> companion_ff == 4'h0)  // [RQ12]
    else $error("first group not on lowest companion");

endmodule

// file: core/cap_params_bank.sv
`timescale 1ns/1ns
// What this block does
// RQ1 - With the routing rule flag set, each root port goes to the companion named in the array.
// RQ2 - Bit 4 of the structural register shows power switches and governs the port power field.
// RQ3 - Bits 3 to 0 give the port count, 1 to 15, and limit which port registers exist.
// RQ4 - The 32-bit capability register sits at offset 08 of the memory window.
// RQ5 - Capability bits 31 to 8 and 3 to 2 are reserved and read zero.
// RQ6 - Threshold in bits 7 to 4; with top bit clear the low bits count microframes held.
// RQ7 - With threshold top bit set, software assumes a whole frame may be cached.
// RQ8 - Programmable list flag clear: list is 1024 entries and the size field reads zero.
// RQ9 - Programmable list flag set: software may write the size field for a shorter list.
// RQ10 - Software keeps the frame list on a 4 K page boundary.
// RQ11 - Bit 0 reads 0 for 32-bit pointers and 1 for 64-bit pointers.
// RQ12 - Routing rule flag clear: ports go in groups to companions by ascending function.
// RQ13 - After reset the capability register reads 0x00000012.
// RQ14 - Writes to both parameter registers are ignored; reads return fixed values.
module cap_params_bank
  import cap_params_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire cap_params_pkg::reg_req_t req,
  input  wire logic [63:0]              routing_array,
  input  wire logic [3:0]               port_index,
  input  wire logic [14:0]              port_power_req,
  output logic      [31:0]              rdata_ff,
  output logic                          rvalid_ff,
  output logic                          addr_hit,
  output logic      [1:0]               list_size_field,
  output logic      [14:0]              port_power_on,
  output logic      [14:0]              port_present,
  output logic      [3:0]               companion_ff
);

  // ****************************************
  // Fixed parameter registers
  // ****************************************
  cap_fields_t  cap_ff;
  logic         routing_rule_flag;
  logic         power_switch_flag;
  logic [3:0]   port_count;
  logic [1:0]   list_size_ff;
  logic [14:0]  power_ff;
  bank_state_t  state_ff;
  logic [31:0]  nxt_rdata;
  logic [31:0]  struct_word;
  logic [31:0]  cap_word;

  function automatic logic [31:0] cap_pack(input cap_fields_t f);
    logic [31:0] w;
    w = 32'h0000_0000;                                                      // [RQ5]
    w[ISO_LSB +: 4] = f.iso_threshold;                                      // [RQ6]
    w[PROG_BIT]     = f.programmable_list_flag;
    w[WIDE_BIT]     = f.wide_pointer_flag;                                  // [RQ11]
    return w;
  endfunction

  assign routing_rule_flag = ROUTE_RESET;
  assign power_switch_flag = POWER_RESET;
  assign port_count        = PORT_COUNT;                                    // [RQ3]

  // Held in flops so reset is the one moment the values appear
  always_ff @(posedge clock) begin
    if (reset) begin
      cap_ff   <= '{iso_threshold: ISO_RESET, programmable_list_flag: PROG_RESET,
                    wide_pointer_flag: WIDE_RESET};                         // [RQ13]
      state_ff <= ST_RESET;
    end else begin
      state_ff <= ST_RUN;                                                   // [RQ14]
    end
  end

  always_comb begin
    struct_word = 32'h0000_0000;
    struct_word[ROUTE_BIT]        = routing_rule_flag;
    struct_word[POWER_BIT]        = power_switch_flag;                      // [RQ2]
    struct_word[PORTS_LSB +: 4]   = port_count;                             // [RQ3]
    struct_word[PPC_LSB +: 4]     = PER_COMPANION;
    struct_word[PPC_LSB + 4 +: 4] = COMPANIONS;
    cap_word = cap_pack(cap_ff);
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_comb begin
    addr_hit  = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (req.addr)
      STRUCT_OFFSET: nxt_rdata = struct_word;
      CAP_OFFSET:    nxt_rdata = cap_word;                                  // [RQ4]
      CMD_OFFSET:    nxt_rdata = {28'h0000000, list_size_ff, 2'h0};
      default:       addr_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff  <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= req.rd ? nxt_rdata : 32'h0000_0000;
      rvalid_ff <= req.rd;
    end
  end

  // ****************************************
  // Command list size field
  // ****************************************
  // Writable only when the list length is programmable
  always_ff @(posedge clock) begin
    if (reset) begin
      list_size_ff <= LIST_DEFAULT;
    end else if (!cap_ff.programmable_list_flag) begin
      list_size_ff <= LIST_DEFAULT;                                         // [RQ8]
    end else if (req.wr && req.addr == CMD_OFFSET) begin
      list_size_ff <= req.wdata[LIST_LSB +: 2];                             // [RQ9]
    end
  end

  assign list_size_field = list_size_ff;

  // ****************************************
  // Port power and presence
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      power_ff <= 15'h0000;
    end else begin
      for (int p = 0; p < 15; p++) begin
        // Without switches, ports below the port count are always powered
        power_ff[p] <= (p < int'(port_count)) &&
                       (power_switch_flag ? port_power_req[p] : 1'b1);      // [RQ2] [RQ3]
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 15; p++) begin
      port_present[p] = (p < int'(port_count));                            // [RQ3]
    end
  end

  assign port_power_on = power_ff;

  port_route_map u_route (
    .clock               (clock),
    .reset               (reset),
    .routing_rule_flag   (routing_rule_flag),
    .ports_per_companion (PER_COMPANION),
    .routing_array       (routing_array),
    .port_index          (port_index),
    .companion_ff        (companion_ff)
  );

  // ****************************************
  // Checks
  // ****************************************
  a_cap_read_value: assert property (@(posedge clock) disable iff (reset)
    (req.rd && req.addr == CAP_OFFSET) |=> rdata_ff == CAP_RESET)           // [RQ13]
    else $error("capability read wrong");

  a_cap_reserved_zero: assert property (@(posedge clock) disable iff (reset)
    (req.rd && req.addr == CAP_OFFSET) |=> (rdata_ff[31:8] == 24'h0 && rdata_ff[3:2] == 2'h0))  // [RQ5]
    else $error("reserved bits set");

  a_cap_write_ignored: assert property (@(posedge clock) disable iff (reset)
    (req.wr && req.addr == CAP_OFFSET) |=> cap_word == $past(cap_word))     // [RQ14]
    else $error("capability changed by write");

  a_struct_read_value: assert property (@(posedge clock) disable iff (reset)
    (req.rd && req.addr == STRUCT_OFFSET) |=>
      (rdata_ff[3:0] == PORT_COUNT && rdata_ff[POWER_BIT] == POWER_RESET))  // [RQ3]
    else $error("structural read wrong");

  a_port_count_nonzero: assert property (@(posedge clock) disable iff (reset)
    port_count != 4'h0)                                                     // [RQ3]
    else $error("port count zero");

  a_list_size_locked: assert property (@(posedge clock) disable iff (reset)
    !cap_ff.programmable_list_flag |-> list_size_field == 2'h0)             // [RQ8]
    else $error("list size not cleared");

  a_list_size_write: assert property (@(posedge clock) disable iff (reset)
    (cap_ff.programmable_list_flag && req.wr && req.addr == CMD_OFFSET) |=>
      list_size_field == $past(req.wdata[LIST_LSB +: 2]))                   // [RQ9]
    else $error("list size write lost");

  a_power_follows: assert property (@(posedge clock) disable iff (reset)
    (power_switch_flag && port_count > 4'h0) |=>
      port_power_on[0] == $past(port_power_req[0]))                         // [RQ2]
    else $error("port power not switched");

  a_iso_threshold: assert property (@(posedge clock) disable iff (reset)
    (req.rd && req.addr == CAP_OFFSET) |=> rdata_ff[7:4] == ISO_RESET)      // [RQ6]
    else $error("threshold wrong");

  a_wide_pointer: assert property (@(posedge clock) disable iff (reset)
    (req.rd && req.addr == CAP_OFFSET) |=> rdata_ff[0] == WIDE_RESET)       // [RQ11]
    else $error("pointer width flag wrong");

  c_cap_read:    cover property (@(posedge clock) req.rd && req.addr == CAP_OFFSET);
  c_struct_read: cover property (@(posedge clock) req.rd && req.addr == STRUCT_OFFSET);
  c_list_write:  cover property (@(posedge clock) req.wr && req.addr == CMD_OFFSET);
  c_bad_addr:    cover property (@(posedge clock) req.rd && !addr_hit);

endmodule

// file: bench/cap_params_bank_tb.sv
`timescale 1ns/1ns
module cap_params_bank_tb
  import cap_params_pkg::*;
;
  // ****************************************
  // Signals and expected words
  // ****************************************
  localparam logic [31:0] STRUCT_EXP = {16'h0000, COMPANIONS, PER_COMPANION, ROUTE_RESET,
                                        2'b00, POWER_RESET, PORT_COUNT};
  localparam logic [31:0] CAP_EXP    = {24'h000000, ISO_RESET, 2'b00, PROG_RESET, WIDE_RESET};
  typedef struct packed {
    logic [7:0]  addr;
    logic        hit;
    logic [31:0] data;
  } row_t;
  logic        clock;
  logic        reset;
  reg_req_t    req;
  logic [63:0] routing_array;
  logic [3:0]  port_index;
  logic [14:0] port_power_req;
  logic [31:0] rdata_ff;
  logic        rvalid_ff;
  logic        addr_hit;
  logic [1:0]  list_size_field;
  logic [14:0] port_power_on;
  logic [14:0] port_present;
  logic [3:0]  companion_ff;
  int          error_cnt;
  int          comparisons;
  int          cycles;
  row_t        rows [5];

  cap_params_bank u_dut (
    .clock           (clock),
    .reset           (reset),
    .req             (req),
    .routing_array   (routing_array),
    .port_index      (port_index),
    .port_power_req  (port_power_req),
    .rdata_ff        (rdata_ff),
    .rvalid_ff       (rvalid_ff),
    .addr_hit        (addr_hit),
    .list_size_field (list_size_field),
    .port_power_on   (port_power_on),
    .port_present    (port_present),
    .companion_ff    (companion_ff)
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic end_of_test();
    $display("counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Generous ceiling; whole run is under 70 cycles
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic h, input logic [31:0] d);
    @(posedge clock);
    req.rd   <= 1'b1;
    req.addr <= a;
    #1;
    chk(32'(addr_hit), 32'(h), "address decode");
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(32'(rvalid_ff), 32'h1, "read valid");
    chk(rdata_ff, d, "read data");
  endtask

  // Returns after the taking edge so register effects have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    error_cnt      = 0;
    comparisons    = 0;
    cycles         = 0;
    reset          = 1'b1;
    req            = '0;
    routing_array  = 64'hFEDC_BA98_7654_3210;
    port_index     = 4'h0;
    port_power_req = 15'h0000;
    rows = '{'{8'h04, 1'b1, STRUCT_EXP}, '{8'h08, 1'b1, CAP_EXP}, '{8'h00, 1'b0, 32'h0},
             '{8'h10, 1'b0, 32'h0}, '{8'hFC, 1'b0, 32'h0}};
    repeat (16) @(posedge clock);
    #1;
    chk(rdata_ff, 32'h0, "reset read data");
    chk(32'(rvalid_ff), 32'h0, "reset valid");
    chk(32'(list_size_field), 32'h0, "reset list size");
    chk(32'(port_power_on), 32'h0, "reset power");
    chk(32'(companion_ff), 32'h0, "reset companion");
    @(posedge clock);
    reset <= 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      rd_chk(rows[i].addr, rows[i].hit, rows[i].data);
    end
    $display("test read table done");
    chk(32'(port_present), 32'h0000_000F, "present ports");
    @(posedge clock);
    req.rd   <= 1'b1;
    req.addr <= CAP_OFFSET;
    @(posedge clock);
    req.addr <= STRUCT_OFFSET;
    #1;
    chk(rdata_ff, CAP_EXP, "back to back first");
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(rdata_ff, STRUCT_EXP, "back to back second");
    @(posedge clock);
    #1;
    chk(rdata_ff, 32'h0, "idle data after read");
    chk(32'(rvalid_ff), 32'h0, "idle valid after read");
    $display("test back to back done");
    wr(STRUCT_OFFSET, 32'hFFFF_FFFF);
    wr(CAP_OFFSET, 32'hFFFF_FFFF);
    rd_chk(STRUCT_OFFSET, 1'b1, STRUCT_EXP);
    rd_chk(CAP_OFFSET, 1'b1, CAP_EXP);
    // Threshold top bit clear, so software may not assume whole-frame caching
    chk(32'(rdata_ff[7]), 32'(ISO_RESET[3]), "threshold top bit");
    $display("test ignored writes done");
    // List base alignment is software's duty; no base register lives here
    for (int v = 1; v < 4; v++) begin
      wr(CMD_OFFSET, 32'(v) << LIST_LSB);
      chk(32'(list_size_field), 32'(v), "list size write");
    end
    wr(CMD_OFFSET, 32'hFFFF_FFF3);
    chk(32'(list_size_field), 32'h0, "list size other bits");
    $display("test list size done");
    // Array holds identity routing so the grouped rule gives a different answer
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      port_index <= 4'(p);
      @(posedge clock);
      #1;
      chk(32'(companion_ff), 32'(p) / 32'(PER_COMPANION), "companion");
    end
    $display("test routing done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      port_power_req <= (k == 0) ? 15'h7FFF : 15'h0005;
      repeat (2) @(posedge clock);
      #1;
      chk(32'(port_power_on), (k == 0) ? 32'h000F : 32'h0005, "port power");
    end
    $display("test port power done");
    wr(CMD_OFFSET, 32'h0000_0008);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk(32'(list_size_field), 32'h0, "list after second reset");
    rd_chk(CAP_OFFSET, 1'b1, CAP_EXP);
    $display("test second reset done");
    end_of_test();
  end
endmodule
